// *** logic/fcs_defines.svh ***
// Register offsets, field positions, reset values and command codes of the flash command block
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define FCS_ADDR_W          8
`define FCS_OFS_MODE        8'h00
`define FCS_OFS_COMMAND     8'h04
`define FCS_OFS_STATUS      8'h08
`define FCS_OFS_RESULT      8'h0C
`define FCS_OFS_EVENT       8'h20
`define FCS_OFS_EVENT_MASK  8'h24

// ----------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------
`define FCS_KEY_VALUE       8'h5A
`define FCS_KEY_LSB         24
`define FCS_ARG_LSB         8

// ----------------------------------------------------------------------
// Status, mode and event bit positions and reset values
// ----------------------------------------------------------------------
`define FCS_ST_READY        0
`define FCS_ST_CMD_ERR      1
`define FCS_ST_LOCK_ERR     2
`define FCS_ST_VERIFY_ERR   3
`define FCS_MODE_READY_IE   0
`define FCS_MODE_RESET      32'h0400_0000
`define FCS_MODE_WMASK      32'h0501_0F01
`define FCS_EV_DONE         0
`define FCS_EV_CMD_ERR      1
`define FCS_EV_LOCK_ERR     2
`define FCS_EV_VERIFY_ERR   3
`define FCS_EV_N            4

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define FCS_CMD_GET_DESC    8'h00
`define FCS_CMD_WR_PAGE     8'h01
`define FCS_CMD_WR_PAGE_LK  8'h02
`define FCS_CMD_ER_WR       8'h03
`define FCS_CMD_ER_WR_LK    8'h04
`define FCS_CMD_ERASE_ALL   8'h05
`define FCS_CMD_ERASE_GRP   8'h07
`define FCS_CMD_SET_LOCK    8'h08
`define FCS_CMD_CLR_LOCK    8'h09
`define FCS_CMD_GET_LOCK    8'h0A
`define FCS_CMD_SET_NVB     8'h0B
`define FCS_CMD_CLR_NVB     8'h0C
`define FCS_CMD_GET_NVB     8'h0D
`define FCS_CMD_UID_START   8'h0E
`define FCS_CMD_UID_STOP    8'h0F
`define FCS_CMD_GET_CALIB   8'h10
`define FCS_CMD_ERASE_SECT  8'h11
`define FCS_CMD_SIG_WRITE   8'h12
`define FCS_CMD_SIG_ERASE   8'h13
`define FCS_CMD_SIG_START   8'h14
`define FCS_CMD_SIG_STOP    8'h15

`endif

// *** logic/fcs_pkg.sv ***
// Types shared by the flash command block modules
package fcs_pkg;

  // Operation class handed to the flash array
  typedef enum logic [3:0] {
    FCS_OP_QUERY,
    FCS_OP_PROGRAM,
    FCS_OP_ERASE_ALL,
    FCS_OP_ERASE_GROUP,
    FCS_OP_ERASE_SECTOR,
    FCS_OP_LOCK,
    FCS_OP_NVBIT,
    FCS_OP_SIGNATURE
  } fcs_op_t;

  // Controller sequencing state
  typedef enum logic {
    FCS_ST_IDLE,
    FCS_ST_BUSY
  } fcs_state_t;

endpackage

// *** logic/fcs_cmd_if.sv ***
// Command word and its decoded operation between the top and the decoder
`timescale 1ns/1ps
interface fcs_cmd_if;
  logic [31:0]      word;
  logic             key_ok;
  logic             code_ok;
  logic             verify_op;
  fcs_pkg::fcs_op_t kind;
  logic [15:0]      page;
  logic [15:0]      count;
  logic [15:0]      index;

  modport top (output word, input key_ok, code_ok, verify_op, kind, page, count, index);
  modport dec (input word, output key_ok, code_ok, verify_op, kind, page, count, index);
endinterface

// *** logic/fcs_decode.sv ***
// Decoder of the keyed command word into an operation for the flash array
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_decode
  import fcs_pkg::*;
#(
  parameter int PAGES_PER_SECTOR = 128
) (
  fcs_cmd_if.dec cmd
);

  logic [7:0]  code;
  logic [15:0] arg;
  logic [15:0] grp_size;

  // ----------------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------------
  assign code     = cmd.word[7:0];
  assign arg      = cmd.word[`FCS_ARG_LSB +: 16];
  assign grp_size = 16'h0004 << arg[1:0];
  assign cmd.key_ok = (cmd.word[`FCS_KEY_LSB +: 8] == `FCS_KEY_VALUE);

  // Code decode; unlisted codes are flagged invalid
  always_comb begin
    cmd.code_ok   = 1'b1;
    cmd.verify_op = 1'b0;
    cmd.kind      = FCS_OP_QUERY;
    cmd.page      = 16'h0000;
    cmd.count     = 16'h0001;
    cmd.index     = 16'h0000;
    case (code)
      `FCS_CMD_GET_DESC, `FCS_CMD_UID_START, `FCS_CMD_UID_STOP, `FCS_CMD_GET_CALIB,
      `FCS_CMD_SIG_START, `FCS_CMD_SIG_STOP: begin
        cmd.kind = FCS_OP_QUERY;
      end
      `FCS_CMD_WR_PAGE, `FCS_CMD_WR_PAGE_LK, `FCS_CMD_ER_WR, `FCS_CMD_ER_WR_LK: begin
        cmd.kind      = FCS_OP_PROGRAM;
        cmd.page      = arg;
        cmd.verify_op = 1'b1;
      end
      `FCS_CMD_ERASE_ALL: begin
        // Count zero means the whole array; the argument plays no part
        cmd.kind      = FCS_OP_ERASE_ALL;
        cmd.count     = 16'h0000;
        cmd.verify_op = 1'b1;
      end
      `FCS_CMD_ERASE_GRP: begin
        // Masking the low bits gives size times the aligned upper bits;
        // bits between code and alignment are assumed zero by software
        cmd.kind      = FCS_OP_ERASE_GROUP;
        cmd.count     = grp_size;
        cmd.page      = arg & ~(grp_size - 16'h0001);
        cmd.verify_op = 1'b1;
      end
      `FCS_CMD_ERASE_SECT: begin
        // Any page of the sector selects the whole sector
        cmd.kind      = FCS_OP_ERASE_SECTOR;
        cmd.count     = 16'(PAGES_PER_SECTOR);
        cmd.page      = arg & ~(16'(PAGES_PER_SECTOR) - 16'h0001);
        cmd.verify_op = 1'b1;
      end
      `FCS_CMD_SET_LOCK, `FCS_CMD_CLR_LOCK, `FCS_CMD_GET_LOCK: begin
        cmd.kind = FCS_OP_LOCK;
        cmd.page = arg;
      end
      `FCS_CMD_SET_NVB, `FCS_CMD_CLR_NVB, `FCS_CMD_GET_NVB: begin
        cmd.kind  = FCS_OP_NVBIT;
        cmd.index = arg;
      end
      `FCS_CMD_SIG_WRITE, `FCS_CMD_SIG_ERASE: begin
        cmd.kind      = FCS_OP_SIGNATURE;
        cmd.verify_op = 1'b1;
      end
      default: begin
        cmd.code_ok = 1'b0;
      end
    endcase
  end

endmodule

// *** logic/fcs_top.sv ***
// Flash command, status and result interface with its register port
// What this block does
// - Sector erase: any page selects whole sector
// - Group erase: size code, aligned start page
// - Program commands take argument as page
// - Lock commands take argument as page
// - Nonvolatile-bit commands take argument as index
// - Command runs only with correct key
// - Ready reads one when idle, zero busy
// - Ready with interrupt enable raises interrupt
// - Bad code or key in an idle command write sets command error
// - Locked-region program or erase sets lock error
// - Status read or idle command write clears command and lock errors
// - Verify failure sets, pass clears verify error
// - Result register yields successive words per read
// - Low byte decoded per command map
// - Mode ready-enable bit gates ready interrupt
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_top
  import fcs_pkg::*;
#(
  parameter int PAGES_PER_SECTOR = 128,
  parameter int RESULT_DEPTH     = 4
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic [`FCS_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  output logic                        irq,
  output logic                        ready_flag,
  output logic                        arr_req,
  output logic      [7:0]             arr_cmd,
  output fcs_op_t                     arr_kind,
  output logic      [15:0]            arr_page,
  output logic      [15:0]            arr_count,
  output logic      [15:0]            arr_index,
  input  wire logic                   arr_done,
  input  wire logic                   arr_lock_hit,
  input  wire logic                   arr_verify_fail,
  input  wire logic                   arr_res_valid,
  input  wire logic [31:0]            arr_res_word
);

  localparam int PW = (RESULT_DEPTH > 1) ? $clog2(RESULT_DEPTH) : 1;

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    fcs_state_t                        state;
    logic                              ready;
    logic                              cmd_err;
    logic                              lock_err;
    logic                              ver_err;
    logic [31:0]                       mode;
    logic [`FCS_EV_N-1:0]              evt;
    logic [`FCS_EV_N-1:0]              emask;
    logic [31:0]                       rdata;
    logic                              req;
    logic [7:0]                        cmd;
    fcs_op_t                           kind;
    logic                              verify;
    logic [15:0]                       page;
    logic [15:0]                       count;
    logic [15:0]                       index;
    logic [RESULT_DEPTH-1:0][31:0]     res;
    logic [PW-1:0]                     wp;
    logic [PW-1:0]                     rp;
    logic [PW:0]                       fill;
  } fcs_regs_t;

  fcs_regs_t st_q;
  fcs_regs_t st_d;

  fcs_cmd_if cmd_bus ();

  logic cmd_wr;
  logic stat_rd;
  logic res_rd;
  logic push;
  logic pop;

  // ----------------------------------------------------------------------
  // Command decoder
  // ----------------------------------------------------------------------
  fcs_decode #(
    .PAGES_PER_SECTOR (PAGES_PER_SECTOR)
  ) u_decode (
    .cmd (cmd_bus.dec)
  );

  assign cmd_bus.word = wdata;

  // Access decode and result queue handshakes
  assign cmd_wr  = wr && (addr == `FCS_OFS_COMMAND);
  assign stat_rd = rd && (addr == `FCS_OFS_STATUS);
  assign res_rd  = rd && (addr == `FCS_OFS_RESULT);
  // Words arriving with the queue full are dropped; depth must cover the longest result
  assign push    = arr_res_valid && (st_q.state == FCS_ST_BUSY)
                   && (st_q.fill != (PW+1)'(RESULT_DEPTH));
  assign pop     = res_rd && (st_q.fill != '0);

  // ----------------------------------------------------------------------
  // Next-state logic: clears first, then sets, so a set in the same cycle wins
  // ----------------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.rdata = 32'h0000_0000;

    // Register reads; data stands only in the following cycle
    if (rd) begin
      case (addr)
        `FCS_OFS_MODE:       st_d.rdata = st_q.mode;
        `FCS_OFS_STATUS:     st_d.rdata = {28'h000_0000, st_q.ver_err, st_q.lock_err,
                                           st_q.cmd_err, st_q.ready};
        `FCS_OFS_RESULT:     st_d.rdata = (st_q.fill != '0) ? st_q.res[st_q.rp]
                                                             : 32'h0000_0000;
        `FCS_OFS_EVENT:      st_d.rdata = {{(32-`FCS_EV_N){1'b0}}, st_q.evt};
        `FCS_OFS_EVENT_MASK: st_d.rdata = {{(32-`FCS_EV_N){1'b0}}, st_q.emask};
        default:             st_d.rdata = 32'h0000_0000;
      endcase
    end

    // Command and lock error flags clear on status read or on command write while ready
    if (stat_rd || (cmd_wr && st_q.ready)) begin
      st_d.cmd_err  = 1'b0;
      st_d.lock_err = 1'b0;
    end

    // Plain register writes; event bits clear by writing one
    if (wr) begin
      case (addr)
        `FCS_OFS_MODE:       st_d.mode  = wdata & `FCS_MODE_WMASK;
        `FCS_OFS_EVENT:      st_d.evt   = st_q.evt & ~wdata[`FCS_EV_N-1:0];
        `FCS_OFS_EVENT_MASK: st_d.emask = wdata[`FCS_EV_N-1:0];
        default:             st_d.evt   = st_d.evt;
      endcase
    end

    // Result queue: a read advances to the next word
    if (pop) begin
      st_d.rp = (st_q.rp == PW'(RESULT_DEPTH - 1)) ? '0 : st_q.rp + 1'b1;
    end
    if (push) begin
      st_d.res[st_q.wp] = arr_res_word;
      st_d.wp = (st_q.wp == PW'(RESULT_DEPTH - 1)) ? '0 : st_q.wp + 1'b1;
    end
    st_d.fill = st_q.fill + (PW+1)'(push) - (PW+1)'(pop);

    case (st_q.state)
      FCS_ST_IDLE: begin
        // Busy writes never reach here, so the running operation is untouched
        if (cmd_wr && st_q.ready) begin
          if (!cmd_bus.key_ok || !cmd_bus.code_ok) begin
            st_d.cmd_err                = 1'b1;
            st_d.evt[`FCS_EV_CMD_ERR]   = 1'b1;
          end else begin
            st_d.state  = FCS_ST_BUSY;
            st_d.ready  = 1'b0;
            st_d.req    = 1'b1;
            st_d.cmd    = wdata[7:0];
            st_d.kind   = cmd_bus.kind;
            st_d.verify = cmd_bus.verify_op;
            st_d.page   = cmd_bus.page;
            st_d.count  = cmd_bus.count;
            st_d.index  = cmd_bus.index;
            // A new command discards any unread words of the previous result
            st_d.wp     = '0;
            st_d.rp     = '0;
            st_d.fill   = '0;
          end
        end
      end
      FCS_ST_BUSY: begin
        if (arr_done) begin
          st_d.state                 = FCS_ST_IDLE;
          st_d.ready                 = 1'b1;
          st_d.req                   = 1'b0;
          st_d.evt[`FCS_EV_DONE]     = 1'b1;
          if (arr_lock_hit) begin
            st_d.lock_err                = 1'b1;
            st_d.evt[`FCS_EV_LOCK_ERR]   = 1'b1;
          end
          if (st_q.verify) begin
            st_d.ver_err = arr_verify_fail;
            if (arr_verify_fail) begin
              st_d.evt[`FCS_EV_VERIFY_ERR] = 1'b1;
            end
          end
        end
      end
      default: begin
        st_d.state = FCS_ST_IDLE;
        st_d.ready = 1'b1;
        st_d.req   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register, frozen while the clock enable is low
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q          <= '0;
      st_q.state    <= FCS_ST_IDLE;
      st_q.ready    <= 1'b1;
      st_q.mode     <= `FCS_MODE_RESET;
      st_q.kind     <= FCS_OP_QUERY;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign rdata      = st_q.rdata;
  assign ready_flag = st_q.ready;
  assign arr_req    = st_q.req;
  assign arr_cmd    = st_q.cmd;
  assign arr_kind   = st_q.kind;
  assign arr_page   = st_q.page;
  assign arr_count  = st_q.count;
  assign arr_index  = st_q.index;

  // Level interrupt: ready gated by the mode enable, plus unmasked sticky events
  assign irq = (st_q.ready && st_q.mode[`FCS_MODE_READY_IE])
               || ((st_q.evt & st_q.emask) != '0);

endmodule

// *** verif/fcs_checker.sv ***
// Concurrent checks of the flash command block, bound to its top module
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_checker
  import fcs_pkg::*;
#(
  parameter int PAGES_PER_SECTOR = 128,
  parameter int RESULT_DEPTH     = 4
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        irq,
  input wire logic        ready_flag,
  input wire logic        arr_req,
  input wire logic [7:0]  arr_cmd,
  input wire logic [15:0] arr_page,
  input wire logic [15:0] arr_count,
  input wire logic [15:0] arr_index,
  input wire logic        arr_done
);
  logic        cmd_wr, key_ok, code_ok, acc, ie_q, ie_d;
  logic [7:0]  code;
  logic [15:0] arg;

  // Bus cycle decode as seen from the pins
  assign code    = wdata[7:0];
  assign arg     = wdata[23:8];
  assign cmd_wr  = ce && wr && addr == `FCS_OFS_COMMAND;
  assign key_ok  = wdata[31:24] == `FCS_KEY_VALUE;
  assign code_ok = code <= 8'h15 && code != 8'h06;
  assign acc     = cmd_wr && ready_flag && key_ok && code_ok;
  // Shadow of the ready interrupt enable, since the mode register is not a port
  assign ie_d    = (ce && wr && addr == `FCS_OFS_MODE) ? wdata[`FCS_MODE_READY_IE] : ie_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) ie_q <= 1'b0;
    else ie_q <= ie_d;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_bad_wr;
    cmd_wr && ready_flag && !key_ok;
  endsequence
  sequence s_st_rd;
    ce && rd && addr == `FCS_OFS_STATUS;
  endsequence

  AST_KEY: assert property (s_bad_wr |=> ready_flag && !arr_req)
    else $error("bad key launched an operation");
  AST_ACCEPT: assert property (acc |=> !ready_flag && arr_req && arr_cmd == $past(code))
    else $error("accepted command did not start");
  AST_DONE: assert property (ce && !ready_flag && arr_done |=> ready_flag && !arr_req)
    else $error("ready not back after done");
  AST_BUSY: assert property (!ready_flag && !(ce && arr_done)
    |=> !ready_flag && $stable(arr_cmd) && $stable(arr_page))
    else $error("busy operation disturbed");
  AST_RDST: assert property (s_st_rd |=> rdata[0] == $past(ready_flag))
    else $error("status ready bit wrong");
  AST_CMDE: assert property (s_bad_wr ##1 s_st_rd |=> rdata[1])
    else $error("command error not reported");
  AST_IRQ: assert property (ready_flag && ie_q |-> irq)
    else $error("ready interrupt missing");
  AST_PAGE: assert property (acc && code inside {[8'h01:8'h04], [8'h08:8'h0A]}
    |=> arr_page == $past(arg))
    else $error("page argument not used");
  AST_NVB: assert property (acc && code inside {[8'h0B:8'h0D]} |=> arr_index == $past(arg))
    else $error("bit index not used");
  AST_EA: assert property (acc && code == `FCS_CMD_ERASE_ALL
    |=> arr_page == 16'h0 && arr_count == 16'h0)
    else $error("erase all used its argument");
  // Start page is worked out from the size code itself, not from the count output
  AST_GRP: assert property (acc && code == `FCS_CMD_ERASE_GRP
    |=> arr_count == (16'h4 << $past(arg[1:0]))
    && arr_page == ($past(arg) & ~((16'h4 << $past(arg[1:0])) - 16'h1)))
    else $error("group erase range wrong");
  AST_SECT: assert property (acc && code == `FCS_CMD_ERASE_SECT
    |=> arr_count == 16'(PAGES_PER_SECTOR)
    && arr_page == ($past(arg) & ~16'(PAGES_PER_SECTOR - 1)))
    else $error("sector erase range wrong");
endmodule

bind fcs_top fcs_checker #(.PAGES_PER_SECTOR(PAGES_PER_SECTOR), .RESULT_DEPTH(RESULT_DEPTH)) i_chk (
  .clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq), .ready_flag(ready_flag), .arr_req(arr_req), .arr_cmd(arr_cmd),
  .arr_page(arr_page), .arr_count(arr_count), .arr_index(arr_index), .arr_done(arr_done)
);

// *** verif/fcs_tb.sv ***
// Self-checking bench of the flash command block through its register port
`timescale 1ns/1ps
`include "fcs_defines.svh"
module testbench
  import fcs_pkg::*;
;
  localparam int PPS = 128;
  typedef struct packed {logic [31:0] w; logic [15:0] pg; logic [15:0] cnt;} fcs_row_t;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        arr_done = 1'b0;
  logic        arr_lock_hit = 1'b0;
  logic        arr_verify_fail = 1'b0;
  logic        arr_res_valid = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] arr_res_word = 32'h0;
  logic [31:0] rdata, d;
  logic        irq, ready_flag, arr_req, verr;
  logic [7:0]  arr_cmd, c;
  fcs_op_t     arr_kind;
  logic [15:0] arr_page, arr_count, arr_index;
  int          errors = 0;
  int          n_compared = 0;
  // Every command code; group rows keep the undefined argument bits at zero
  fcs_row_t    rows [24] = '{
    '{32'h5A000000, 16'h0, 16'h1}, '{32'h5A012301, 16'h123, 16'h1},
    '{32'h5A004502, 16'h45, 16'h1}, '{32'h5A006703, 16'h67, 16'h1},
    '{32'h5A008904, 16'h89, 16'h1}, '{32'h5A777705, 16'h0, 16'h0},
    '{32'h5A004007, 16'h40, 16'h4}, '{32'h5A004907, 16'h48, 16'h8},
    '{32'h5A005207, 16'h50, 16'h10}, '{32'h5A006307, 16'h60, 16'h20},
    '{32'h5A00AA08, 16'hAA, 16'h1}, '{32'h5A00BB09, 16'hBB, 16'h1},
    '{32'h5A00CC0A, 16'hCC, 16'h1}, '{32'h5A00030B, 16'h3, 16'h1},
    '{32'h5A00050C, 16'h5, 16'h1}, '{32'h5A00070D, 16'h7, 16'h1},
    '{32'h5A00000E, 16'h0, 16'h1}, '{32'h5A00000F, 16'h0, 16'h1},
    '{32'h5A000010, 16'h0, 16'h1}, '{32'h5A010511, 16'h100, 16'h80},
    '{32'h5A000012, 16'h0, 16'h1}, '{32'h5A000013, 16'h0, 16'h1},
    '{32'h5A000014, 16'h0, 16'h1}, '{32'h5A000015, 16'h0, 16'h1}};
  // Address and value after reset; the command offset reads as zero
  logic [39:0] rv [7] = '{{8'h00, 32'h04000000}, {8'h08, 32'h1}, {8'h0C, 32'h0},
    {8'h10, 32'h0}, {8'h20, 32'h0}, {8'h24, 32'h0}, {8'h04, 32'h0}};

  // Free-running 50 MHz clock
  always #10 clock = ~clock;

  fcs_top #(.PAGES_PER_SECTOR(PPS), .RESULT_DEPTH(4)) i_dut (
    .clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .ready_flag(ready_flag), .arr_req(arr_req), .arr_cmd(arr_cmd),
    .arr_kind(arr_kind), .arr_page(arr_page), .arr_count(arr_count), .arr_index(arr_index),
    .arr_done(arr_done), .arr_lock_hit(arr_lock_hit), .arr_verify_fail(arr_verify_fail),
    .arr_res_valid(arr_res_valid), .arr_res_word(arr_res_word));

  // ------------------------------------------------------------
  // Bus and array tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Strobe is left up so a read may follow with no gap
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= v;
  endtask
  task automatic idle;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    ce <= 1'b1;
    #1;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clock);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic dn(input logic lk, input logic vf);
    @(posedge clock);
    arr_res_valid <= 1'b0;
    arr_done <= 1'b1;
    arr_lock_hit <= lk;
    arr_verify_fail <= vf;
    @(posedge clock);
    arr_done <= 1'b0;
    #1;
  endtask
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    give_verdict;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    verr = 1'b0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      c = rows[i].w[7:0];
      bus_wr(`FCS_OFS_COMMAND, rows[i].w);
      idle;
      chk(32'({ready_flag, arr_req}), 32'h1);
      chk(32'(arr_cmd), 32'(c));
      chk(32'(arr_count), 32'(rows[i].cnt));
      if (c inside {[8'h0B:8'h0D]}) chk(32'(arr_index), 32'(rows[i].pg));
      else if (c inside {[8'h01:8'h0A], 8'h11}) chk(32'(arr_page), 32'(rows[i].pg));
      dn(1'b0, i[0]);
      // Only program, erase and signature write or erase update the verify flag
      if (c inside {[8'h01:8'h05], 8'h07, [8'h11:8'h13]}) verr = i[0];
      bus_rd(`FCS_OFS_STATUS);
      chk(d, {28'h0, verr, 3'b001});
    end
    $display("test command table done");
    bus_wr(`FCS_OFS_COMMAND, 32'h5A001201);
    idle;
    chk(32'(arr_kind), 32'(FCS_OP_PROGRAM));
    bus_rd(`FCS_OFS_STATUS);
    chk(d, {28'h0, verr, 3'b000});
    bus_wr(`FCS_OFS_COMMAND, 32'h5A003401);
    idle;
    chk(32'(arr_page), 32'h12);
    dn(1'b1, 1'b0);
    chk(32'(ready_flag), 32'h1);
    bus_rd(`FCS_OFS_STATUS);
    chk(d, 32'h5);
    bus_rd(`FCS_OFS_STATUS);
    chk(d, 32'h1);
    $display("test busy and lock done");
    bus_wr(`FCS_OFS_COMMAND, 32'hA5001201);
    bus_rd(`FCS_OFS_STATUS);
    chk(d, 32'h3);
    chk(32'(arr_req), 32'h0);
    bus_wr(`FCS_OFS_COMMAND, 32'h5A000006);
    bus_rd(`FCS_OFS_STATUS);
    chk(d, 32'h3);
    bus_wr(`FCS_OFS_COMMAND, 32'hA5000000);
    bus_wr(`FCS_OFS_COMMAND, 32'h5A000000);
    idle;
    // Five words into a queue of four: the last one is dropped
    for (int k = 0; k < 5; k++) begin
      @(posedge clock);
      arr_res_valid <= 1'b1;
      arr_res_word <= 32'hC0DE0000 + 32'(k);
    end
    dn(1'b0, 1'b0);
    bus_rd(`FCS_OFS_STATUS);
    chk(d, 32'h1);
    for (int k = 0; k < 5; k++) begin
      bus_rd(`FCS_OFS_RESULT);
      chk(d, (k < 4) ? 32'hC0DE0000 + 32'(k) : 32'h0);
    end
    $display("test errors and results done");
    bus_wr(`FCS_OFS_MODE, 32'hFFFFFFFF);
    bus_rd(`FCS_OFS_MODE);
    chk(d, `FCS_MODE_WMASK);
    chk(32'(irq), 32'h1);
    bus_wr(`FCS_OFS_MODE, 32'h0);
    bus_wr(`FCS_OFS_EVENT, 32'hF);
    bus_wr(`FCS_OFS_EVENT_MASK, 32'h1);
    idle;
    chk(32'(irq), 32'h0);
    bus_wr(`FCS_OFS_COMMAND, 32'h5A000001);
    idle;
    dn(1'b0, 1'b0);
    chk(32'(irq), 32'h1);
    bus_wr(`FCS_OFS_EVENT, 32'h1);
    idle;
    chk(32'(irq), 32'h0);
    $display("test interrupts done");
    // Second reset; the mode write with clock enable low must be lost
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus_wr(`FCS_OFS_MODE, 32'h1);
    ce <= 1'b0;
    idle;
    chk(32'(irq), 32'h0);
    foreach (rv[j]) begin
      bus_rd(rv[j][39:32]);
      chk(d, rv[j][31:0]);
    end
    $display("test reset values done");
    give_verdict;
  end
endmodule
